// ### include/sfr_defines.svh
// offsets, field positions, reset values and behaviour summary of the sfr bank
//
// Behaviour
// R01: unimplemented register bits read as zero and ignore writes.
// R02: unmapped register locations decode empty and always read zero.
// R03: upper counter byte hidden; high latch bits copy into it on load.
// R04: global core registers reach one physical register from every bank.
// R05: peripheral flags set on their condition regardless of any enable bit.
// R06: software clears a flag before enabling its interrupt.
// R07: eight flags, bits five and four read-only, all reset to zero.
// R08: reduced variant software keeps parallel port flag and enable clear.
// R09: reduced variant omits fourth and fifth ports; reads return zero.
// R10: software keeps bit six of second flag and enable registers clear.
// R11: accesses complete in one cycle; a write is visible on next read.
// R12: converter done flag reads one after a completed conversion.
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH

// sfr offsets within a bank (byte address is four times the index)
`define SFR_IDX_PORTD4 9'h008
`define SFR_IDX_PORTE5 9'h009
`define SFR_IDX_PCLATCH 9'h00a
`define SFR_IDX_INTCTL 9'h00b
`define SFR_IDX_PFLAGS 9'h00c
`define SFR_IDX_T1H 9'h00f
`define SFR_IDX_T1CTL 9'h010
`define SFR_IDX_T2CNT 9'h011
`define SFR_IDX_T2CTL 9'h012
`define SFR_IDX_SSBUF 9'h013
`define SFR_IDX_SSCTL 9'h014
`define SFR_IDX_C1L 9'h015
`define SFR_IDX_C1H 9'h016
`define SFR_IDX_C1CTL 9'h017
`define SFR_IDX_RXSTAT 9'h018
`define SFR_IDX_TXDATA 9'h019
`define SFR_IDX_RXDATA 9'h01a
`define SFR_IDX_C2L 9'h01b
`define SFR_IDX_C2H 9'h01c
`define SFR_IDX_C2CTL 9'h01d
`define SFR_IDX_ADHI 9'h01e
`define SFR_IDX_ADCTL 9'h01f
`define SFR_IDX_DIR4 9'h088
`define SFR_IDX_DIR5 9'h089
// chosen offsets for the interrupt glue registers
`define SFR_IDX_IRQ_STATUS 9'h1f0
`define SFR_IDX_IRQ_MASK 9'h1f1

// writable bit masks; zero bits ignore writes (unimplemented, or read-only flag and receive status bits)
`define SFR_MASK_T1CTL 8'h3f
`define SFR_MASK_T2CTL 8'h7f
`define SFR_MASK_CCTL 8'h3f
`define SFR_MASK_ADCTL 8'hfd
`define SFR_MASK_PCLATCH 8'h1f
`define SFR_MASK_FIFTH_PARALLEL_PORT 8'h07
`define SFR_MASK_PFLAGS_W 8'hcf
`define SFR_MASK_RXSTAT_W 8'hf9

// flag bit positions
`define SFR_BIT_PARALLEL 7
`define SFR_BIT_CONVDONE 6
`define SFR_BIT_RXFULL 5
`define SFR_BIT_TXEMPTY 4
`define SFR_BIT_GIE 7

`define SFR_RESET_ZERO 8'h00
`define SFR_IRQ_SRC_W 8

`endif

// ### include/sfr_pkg.sv
// types shared by the sfr bank
package sfr_pkg;
    typedef logic [7:0] sfr_byte_t;
    typedef enum logic [1:0] {
        SFR_BANK0 = 2'b00,
        SFR_BANK1 = 2'b01,
        SFR_BANK2 = 2'b10,
        SFR_BANK3 = 2'b11
    } sfr_bank_t;
endpackage

// ### logic/sfr_bank.sv
// sfr bank with peripheral interrupt flags behind an apb slave
`timescale 1ns/10ps
`include "sfr_defines.svh"

module sfr_bank
    import sfr_pkg::*;
#(
    parameter bit HAS_PARALLEL = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] periph_event,
    input wire logic rx_full,
    input wire logic tx_empty,
    input wire logic [7:0] rx_data_in,
    input wire logic [7:0] conv_result_in,
    input wire logic [2:0] rx_errors_in,
    input wire logic counter_load,
    output logic [4:0] pc_high,
    output logic [7:0] timer1_control,
    output logic [7:0] timer2_control,
    output logic [7:0] converter_control_main,
    output logic irq
);

    // ********************************************************************
    // bus decode
    // ********************************************************************
    logic wr_en;
    logic [8:0] idx;
    logic [8:0] loc;
    sfr_bank_t bank_sel;

    // a single-cycle slave: no wait states, never an error
    assign pready = 1'b1; // R11
    assign pslverr = 1'b0;
    assign wr_en = psel & penable & pwrite & pstrb[0];
    assign idx = paddr[10:2];
    assign bank_sel = sfr_bank_t'(idx[8:7]);

    // fold global core registers onto their bank-0 home
    function automatic logic [8:0] fold_global(input logic [8:0] i);
        logic [6:0] off;
        off = i[6:0];
        if (i == `SFR_IDX_IRQ_STATUS || i == `SFR_IDX_IRQ_MASK)
            return i;
        if (off == `SFR_IDX_PCLATCH || off == `SFR_IDX_INTCTL)
            return {2'b00, off}; // R04
        return i;
    endfunction

    assign loc = fold_global(idx);

    // ********************************************************************
    // plain storage registers
    // ********************************************************************
    sfr_byte_t t1h_reg, t1ctl_reg, t2cnt_reg, t2ctl_reg, ssbuf_reg, ssctl_reg;
    sfr_byte_t c1l_reg, c1h_reg, c1ctl_reg, txd_reg, c2l_reg, c2h_reg;
    sfr_byte_t c2ctl_reg, adctl_reg, pclatch_reg, intctl_reg, rxstat_reg;
    sfr_byte_t port4_reg, port5_reg, dir4_reg, dir5_reg;
    logic [4:0] pc_high_reg;
    logic [1:0] bank_unused;

    assign bank_unused = bank_sel;

    // write path; each byte masks off its unimplemented bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            t1h_reg <= `SFR_RESET_ZERO;
            t1ctl_reg <= `SFR_RESET_ZERO;
            t2cnt_reg <= `SFR_RESET_ZERO;
            t2ctl_reg <= `SFR_RESET_ZERO;
            ssbuf_reg <= `SFR_RESET_ZERO;
            ssctl_reg <= `SFR_RESET_ZERO;
            c1l_reg <= `SFR_RESET_ZERO;
            c1h_reg <= `SFR_RESET_ZERO;
            c1ctl_reg <= `SFR_RESET_ZERO;
            txd_reg <= `SFR_RESET_ZERO;
            c2l_reg <= `SFR_RESET_ZERO;
            c2h_reg <= `SFR_RESET_ZERO;
            c2ctl_reg <= `SFR_RESET_ZERO;
            adctl_reg <= `SFR_RESET_ZERO;
            pclatch_reg <= `SFR_RESET_ZERO;
            intctl_reg <= `SFR_RESET_ZERO;
            rxstat_reg <= `SFR_RESET_ZERO;
            port4_reg <= `SFR_RESET_ZERO;
            port5_reg <= `SFR_RESET_ZERO;
            dir4_reg <= `SFR_RESET_ZERO;
            dir5_reg <= `SFR_RESET_ZERO;
        end
        else if (wr_en)
        begin
            unique case (loc)
                `SFR_IDX_T1H: t1h_reg <= pwdata[7:0];
                `SFR_IDX_T1CTL: t1ctl_reg <= pwdata[7:0] & `SFR_MASK_T1CTL; // R01
                `SFR_IDX_T2CNT: t2cnt_reg <= pwdata[7:0];
                `SFR_IDX_T2CTL: t2ctl_reg <= pwdata[7:0] & `SFR_MASK_T2CTL; // R01
                `SFR_IDX_SSBUF: ssbuf_reg <= pwdata[7:0];
                `SFR_IDX_SSCTL: ssctl_reg <= pwdata[7:0];
                `SFR_IDX_C1L: c1l_reg <= pwdata[7:0];
                `SFR_IDX_C1H: c1h_reg <= pwdata[7:0];
                `SFR_IDX_C1CTL: c1ctl_reg <= pwdata[7:0] & `SFR_MASK_CCTL; // R01
                `SFR_IDX_TXDATA: txd_reg <= pwdata[7:0];
                `SFR_IDX_C2L: c2l_reg <= pwdata[7:0];
                `SFR_IDX_C2H: c2h_reg <= pwdata[7:0];
                `SFR_IDX_C2CTL: c2ctl_reg <= pwdata[7:0] & `SFR_MASK_CCTL; // R01
                `SFR_IDX_ADCTL: adctl_reg <= pwdata[7:0] & `SFR_MASK_ADCTL; // R01
                `SFR_IDX_PCLATCH: pclatch_reg <= pwdata[7:0] & `SFR_MASK_PCLATCH; // R03
                `SFR_IDX_INTCTL: intctl_reg <= pwdata[7:0];
                `SFR_IDX_RXSTAT: rxstat_reg <= pwdata[7:0] & `SFR_MASK_RXSTAT_W;
                `SFR_IDX_PORTD4: port4_reg <= HAS_PARALLEL ? pwdata[7:0] : 8'h00; // R09
                `SFR_IDX_PORTE5:
                    port5_reg <= HAS_PARALLEL ? (pwdata[7:0] & `SFR_MASK_FIFTH_PARALLEL_PORT) : 8'h00;
                `SFR_IDX_DIR4: dir4_reg <= HAS_PARALLEL ? pwdata[7:0] : 8'h00; // R09
                `SFR_IDX_DIR5:
                    dir5_reg <= HAS_PARALLEL ? (pwdata[7:0] & `SFR_MASK_FIFTH_PARALLEL_PORT) : 8'h00;
                default: ; // unmapped: write dropped
            endcase
        end
    end

    // ********************************************************************
    // program counter high byte
    // ********************************************************************
    // not on the bus at all; only the latch reaches it, on a counter load
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pc_high_reg <= 5'h00;
        else if (counter_load)
            pc_high_reg <= pclatch_reg[4:0]; // R03
    end

    // ********************************************************************
    // peripheral flags
    // ********************************************************************
    sfr_byte_t pflags_reg;
    sfr_byte_t pflags_next;
    sfr_byte_t ev_sync1_reg, ev_sync2_reg, ev_prev_reg, ev_rise;
    logic wr_flags;

    // events come from other logic, but sync anyway: sources may be async
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ev_sync1_reg <= 8'h00;
            ev_sync2_reg <= 8'h00;
            ev_prev_reg <= 8'h00;
        end
        else
        begin
            ev_sync1_reg <= periph_event;
            ev_sync2_reg <= ev_sync1_reg;
            ev_prev_reg <= ev_sync2_reg;
        end
    end

    assign ev_rise = ev_sync2_reg & ~ev_prev_reg;
    assign wr_flags = wr_en && loc == `SFR_IDX_PFLAGS;

    // set beats a software write in the same cycle; no enable gates the set
    always_comb
    begin
        pflags_next = pflags_reg;
        if (wr_flags)
            pflags_next = (pflags_reg & ~`SFR_MASK_PFLAGS_W)
                | (pwdata[7:0] & `SFR_MASK_PFLAGS_W); // R07
        pflags_next = pflags_next | ev_rise; // R05
        pflags_next[`SFR_BIT_RXFULL] = rx_full; // R07
        pflags_next[`SFR_BIT_TXEMPTY] = tx_empty; // R07
        if (!HAS_PARALLEL)
            pflags_next[`SFR_BIT_PARALLEL] = 1'b0; // R08
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pflags_reg <= `SFR_RESET_ZERO; // R07
        else
            pflags_reg <= pflags_next;
    end

    // ********************************************************************
    // interrupt glue: sticky status, mask, level output
    // ********************************************************************
    sfr_byte_t irq_status_reg, irq_mask_reg;

    // write-one-to-clear; a new event in the same cycle keeps its bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_status_reg <= 8'h00;
        else if (wr_en && loc == `SFR_IDX_IRQ_STATUS)
            irq_status_reg <= (irq_status_reg & ~pwdata[7:0]) | ev_rise;
        else
            irq_status_reg <= irq_status_reg | ev_rise;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask_reg <= 8'h00;
        else if (wr_en && loc == `SFR_IDX_IRQ_MASK)
            irq_mask_reg <= pwdata[7:0];
    end

    assign irq = |(irq_status_reg & irq_mask_reg);

    // ********************************************************************
    // read path
    // ********************************************************************
    sfr_byte_t rd_byte;

    // unmapped and absent locations read zero
    always_comb
    begin
        unique case (loc)
            `SFR_IDX_T1H: rd_byte = t1h_reg;
            `SFR_IDX_T1CTL: rd_byte = t1ctl_reg;
            `SFR_IDX_T2CNT: rd_byte = t2cnt_reg;
            `SFR_IDX_T2CTL: rd_byte = t2ctl_reg;
            `SFR_IDX_SSBUF: rd_byte = ssbuf_reg;
            `SFR_IDX_SSCTL: rd_byte = ssctl_reg;
            `SFR_IDX_C1L: rd_byte = c1l_reg;
            `SFR_IDX_C1H: rd_byte = c1h_reg;
            `SFR_IDX_C1CTL: rd_byte = c1ctl_reg;
            `SFR_IDX_RXSTAT: rd_byte = rxstat_reg | {5'h00, rx_errors_in};
            `SFR_IDX_TXDATA: rd_byte = txd_reg;
            `SFR_IDX_RXDATA: rd_byte = rx_data_in;
            `SFR_IDX_C2L: rd_byte = c2l_reg;
            `SFR_IDX_C2H: rd_byte = c2h_reg;
            `SFR_IDX_C2CTL: rd_byte = c2ctl_reg;
            `SFR_IDX_ADHI: rd_byte = conv_result_in;
            `SFR_IDX_ADCTL: rd_byte = adctl_reg;
            `SFR_IDX_PCLATCH: rd_byte = pclatch_reg; // R04
            `SFR_IDX_INTCTL: rd_byte = intctl_reg; // R04
            `SFR_IDX_PFLAGS: rd_byte = pflags_reg; // R12
            `SFR_IDX_PORTD4: rd_byte = port4_reg; // R09
            `SFR_IDX_PORTE5: rd_byte = port5_reg;
            `SFR_IDX_DIR4: rd_byte = dir4_reg;
            `SFR_IDX_DIR5: rd_byte = dir5_reg;
            `SFR_IDX_IRQ_STATUS: rd_byte = irq_status_reg;
            `SFR_IDX_IRQ_MASK: rd_byte = irq_mask_reg;
            default: rd_byte = 8'h00; // R02
        endcase
    end

    // upper bits read zero; combinational so a read lands in the access cycle
    assign prdata = {24'h000000, rd_byte}; // R11

    assign pc_high = pc_high_reg;
    assign timer1_control = t1ctl_reg;
    assign timer2_control = t2ctl_reg;
    assign converter_control_main = adctl_reg;

endmodule

// ### dv/sfr_bank_checker.sv
// port checker for the sfr bank
`timescale 1ns/10ps
module sfr_bank_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rx_full,
    input wire logic tx_empty,
    input wire logic counter_load,
    input wire logic [4:0] pc_high,
    input wire logic [7:0] timer1_control,
    input wire logic [7:0] timer2_control,
    input wire logic [7:0] converter_control_main
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    logic rd;
    logic [8:0] ix;
    // decoded access, byte address is four times the index
    assign wr = psel && penable && pwrite && pstrb[0];
    assign rd = psel && !pwrite;
    assign ix = paddr[10:2];
    a_bus_ready: assert property (pready && !pslverr)
        else $error("bus answer missing");
    a_upper_zero: assert property (prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (rd && ix == 9'h1e0 |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_t1_write: assert property (wr && ix == 9'h010 |=>
        timer1_control == ($past(pwdata[7:0]) & 8'h3f))
        else $error("timer1 control write wrong");
    a_t2_write: assert property (wr && ix == 9'h012 |=>
        timer2_control == ($past(pwdata[7:0]) & 8'h7f))
        else $error("timer2 control write wrong");
    a_ad_write: assert property (wr && ix == 9'h01f |=>
        converter_control_main == ($past(pwdata[7:0]) & 8'hfd))
        else $error("converter control write wrong");
    a_t1_hold: assert property (!(wr && ix == 9'h010) |=> $stable(timer1_control))
        else $error("timer1 control changed unwritten");
    a_pc_hold: assert property (!counter_load |=> $stable(pc_high))
        else $error("counter high moved without load");
    a_t1_read: assert property (rd && ix == 9'h010 |-> prdata[7:0] == timer1_control)
        else $error("timer1 control read wrong");
    a_flag_mirror: assert property (rd && ix == 9'h00c && $past(presetn) |->
        prdata[5:4] == {$past(rx_full), $past(tx_empty)})
        else $error("read-only flags not mirrored");
endmodule
bind sfr_bank sfr_bank_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .rx_full, .tx_empty,
    .counter_load, .pc_high, .timer1_control, .timer2_control, .converter_control_main);

// ### dv/sfr_bank_tb.sv
// self-checking bench for the sfr bank
`timescale 1ns/10ps
module sfr_bank_tb;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic counter_load = 0;
    logic rx_full = 0;
    logic tx_empty = 0;
    logic [31:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] seed = 32'h3b68ab52;
    logic [31:0] prdata;
    logic [31:0] prdata2;
    logic [7:0] periph_event = 0;
    logic [7:0] rx_data_in = 0;
    logic [7:0] conv_result_in = 0;
    logic [3:0] pstrb = 4'hf;
    logic [2:0] rx_errors_in = 0;
    logic [7:0] q;
    logic [7:0] rd2;
    logic [7:0] t1c;
    logic [7:0] t2c;
    logic [7:0] adc;
    logic [4:0] pc_high;
    logic pready;
    logic pslverr;
    logic irq;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;
    // writable index and mask table; zero mask bits ignore writes (unimplemented or read-only)
    logic [8:0] idx [19] = '{9'h008, 9'h009, 9'h088, 9'h00f, 9'h010, 9'h011, 9'h012,
        9'h013, 9'h014, 9'h015, 9'h016, 9'h017, 9'h018, 9'h019, 9'h01b, 9'h01c,
        9'h01d, 9'h01f, 9'h00a};
    logic [7:0] msk [19] = '{8'hff, 8'h07, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h7f, 8'hff,
        8'hff, 8'hff, 8'hff, 8'h3f, 8'hf9, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hfd, 8'h1f};
    always #5 pclk = ~pclk;
    sfr_bank #(.HAS_PARALLEL(1'b1)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .periph_event,
        .rx_full, .tx_empty, .rx_data_in, .conv_result_in, .rx_errors_in,
        .counter_load, .pc_high, .timer1_control(t1c), .timer2_control(t2c),
        .converter_control_main(adc), .irq);
    // reduced variant sharing the bus, only its read data is watched
    sfr_bank #(.HAS_PARALLEL(1'b0)) dut2 (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata(prdata2), .pready(), .pslverr(),
        .periph_event, .rx_full, .tx_empty, .rx_data_in, .conv_result_in,
        .rx_errors_in, .counter_load, .pc_high(), .timer1_control(),
        .timer2_control(), .converter_control_main(), .irq());
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic conclude();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [8:0] i, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected value at %h exp %h got %h", i, e, g);
        end
    endtask
    // apb transfer; waits for pready, no fixed latency assumed
    task automatic xfer(input logic w, input logic [8:0] i, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {21'h0, i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata[7:0];
        rd2 = prdata2[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd_chk(input logic [8:0] i, input logic [7:0] e);
        xfer(1'b0, i, 8'h00);
        chk(i, e, q);
    endtask
    // hang guard, far above the expected run length
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            conclude();
        end
    end
    initial
    begin
        int k;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(9'h00c, 8'h00);
        for (k = 0; k < 19; k++) rd_chk(idx[k], 8'h00);
        repeat (40)
        begin
            seed = nxt(seed);
            k = seed[12:8] % 19;
            xfer(1'b1, idx[k], seed[7:0]);
            rd_chk(idx[k], seed[7:0] & msk[k]);
        end
        for (k = 0; k < 3; k++)
        begin
            xfer(1'b1, idx[k], 8'hff);
            xfer(1'b0, idx[k], 8'h00);
            chk(idx[k], 8'h00, rd2);
        end
        xfer(1'b1, 9'h08a, 8'h15);
        rd_chk(9'h18a, 8'h15);
        counter_load <= 1'b1;
        @(posedge pclk);
        counter_load <= 1'b0;
        @(posedge pclk);
        chk(9'h00a, 8'h15, {3'h0, pc_high});
        seed = nxt(seed);
        rx_data_in <= seed[15:8];
        conv_result_in <= seed[23:16];
        xfer(1'b1, 9'h01a, ~seed[15:8]);
        rd_chk(9'h01a, seed[15:8]);
        rd_chk(9'h01e, seed[23:16]);
        xfer(1'b1, 9'h1e0, 8'ha5);
        rd_chk(9'h1e0, 8'h00);
        // event with its interrupt masked off still sets the flag
        xfer(1'b1, 9'h1f1, 8'h00);
        periph_event <= 8'h02;
        repeat (6) @(posedge pclk);
        rd_chk(9'h00c, 8'h02);
        chk(9'h1f1, 8'h00, {7'h0, irq});
        xfer(1'b1, 9'h1f1, 8'h02);
        chk(9'h1f1, 8'h01, {7'h0, irq});
        xfer(1'b1, 9'h1f0, 8'h02);
        chk(9'h1f0, 8'h00, {7'h0, irq});
        xfer(1'b1, 9'h00c, 8'h00);
        periph_event <= 8'h42;
        repeat (6) @(posedge pclk);
        rd_chk(9'h00c, 8'h40);
        xfer(1'b1, 9'h00c, 8'h00);
        rd_chk(9'h00c, 8'h00);
        rx_full <= 1'b1;
        xfer(1'b1, 9'h00c, 8'h10);
        rd_chk(9'h00c, 8'h20);
        // stale status cleared before its interrupt is enabled, so no irq
        xfer(1'b1, 9'h1f0, 8'hff);
        xfer(1'b1, 9'h1f1, 8'h40);
        chk(9'h1f1, 8'h00, {7'h0, irq});
        // parallel port event: full variant flags it, reduced one keeps it clear
        periph_event <= 8'hc2;
        repeat (6) @(posedge pclk);
        rd_chk(9'h00c, 8'ha0);
        chk(9'h00c, 8'h20, rd2);
        xfer(1'b1, 9'h00c, 8'h00);
        rd_chk(9'h00c, 8'h20);
        // second flag register is absent; software keeps it clear
        xfer(1'b1, 9'h00d, 8'h00);
        rd_chk(9'h00d, 8'h00);
        // a write without its low byte lane is dropped
        xfer(1'b1, 9'h011, 8'h3c);
        pstrb <= 4'h0;
        xfer(1'b1, 9'h011, 8'hc3);
        pstrb <= 4'hf;
        rd_chk(9'h011, 8'h3c);
        // receive error inputs show in the low bits of the receive status
        xfer(1'b1, 9'h018, 8'h00);
        rx_errors_in <= 3'h6;
        rd_chk(9'h018, 8'h06);
        conclude();
    end
endmodule
